// ### design/udc_counter.sv
`timescale 1ns/10ps
module udc_counter
    import udc_pkg::*;
#(
    parameter int NBLK = 16,
    parameter int SCAN_CYCLES = SCAN_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic power_fail_i,
    input wire logic clear_i,
    input wire logic pulse_i,
    input wire logic dir_i,
    input wire udc_cfg_t cfg_i,
    input wire logic [NBLK*EXT_W-1:0] blk_vals_i,
    output logic [19:0] count_o,
    output logic q_o,
    output logic scan_o
);
    logic [19:0] cnt_q;
    logic pulse_q;
    logic out_q;
    logic [31:0] scan_cnt_q;
    logic scan_tick;
    logic edge_seen;
    logic [19:0] on_ext_thr;
    logic [19:0] off_ext_thr;
    logic [19:0] on_thr;
    logic [19:0] off_thr;
    logic out_d;
    logic signed [EXT_W-1:0] on_src;
    logic signed [EXT_W-1:0] off_src;
    localparam logic signed [EXT_W-1:0] EXT_TOP = $signed({{(EXT_W-20){1'b0}}, CNT_MAX});

    function automatic logic signed [EXT_W-1:0] pick(input logic [NBLK*EXT_W-1:0] v,
                                                      input logic [3:0] idx);
        pick = v[idx*EXT_W +: EXT_W];
    endfunction

    // a live value inside the legal range reaches the comparator untouched
    function automatic logic in_range(input logic signed [EXT_W-1:0] v);
        in_range = (v >= 0) && (v <= EXT_TOP);
    endfunction

    // source block picked by number, its value read afresh every cycle
    assign on_src = pick(blk_vals_i, cfg_i.on_blk);
    assign off_src = pick(blk_vals_i, cfg_i.off_blk);

    udc_clamp #(.W(EXT_W)) u_on_clamp (
        .val_i(on_src),
        .thr_o(on_ext_thr)
    );
    udc_clamp #(.W(EXT_W)) u_off_clamp (
        .val_i(off_src),
        .thr_o(off_ext_thr)
    );

    // local thresholds above the range are pulled down as well
    assign on_thr = cfg_i.on_ext ? on_ext_thr :
        ((cfg_i.on_thr > CNT_MAX) ? CNT_MAX : cfg_i.on_thr);
    assign off_thr = cfg_i.off_ext ? off_ext_thr :
        ((cfg_i.off_thr > CNT_MAX) ? CNT_MAX : cfg_i.off_thr);

    assign edge_seen = pulse_i & ~pulse_q;
    assign scan_tick = (scan_cnt_q == 32'(SCAN_CYCLES - 1));

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scan_cnt_q <= 32'h00000000;
        end else if (scan_tick) begin
            scan_cnt_q <= 32'h00000000;
        end else begin
            scan_cnt_q <= scan_cnt_q + 32'h00000001;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= pulse_i;
        end
    end

    // power loss is modelled by power_fail_i; retained count survives it
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= CNT_RST;
        end else if (power_fail_i && !cfg_i.retain) begin
            cnt_q <= CNT_RST;
        end else if (clear_i) begin
            cnt_q <= CNT_RST;
        end else if (edge_seen && !dir_i && cnt_q < CNT_MAX) begin
            cnt_q <= cnt_q + 20'h00001;
        end else if (edge_seen && dir_i && cnt_q != CNT_RST) begin
            cnt_q <= cnt_q - 20'h00001;
        end
    end

    always_comb begin
        if (on_thr >= off_thr) begin
            if (cnt_q >= on_thr) begin
                out_d = 1'b1;
            end else if (cnt_q < off_thr) begin
                out_d = 1'b0;
            end else begin
                out_d = out_q;
            end
        end else begin
            out_d = (cnt_q >= on_thr) && (cnt_q < off_thr);
        end
    end

    // slow scan means fast trains can overshoot a threshold before the output moves
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_q <= 1'b0;
        end else if (clear_i || power_fail_i) begin
            out_q <= 1'b0;
        end else if (scan_tick) begin
            out_q <= out_d;
        end
    end

    assign count_o = cnt_q;
    assign q_o = out_q;
    assign scan_o = scan_tick;

    // steps shared by the properties below
    sequence live_edge_s;
        edge_seen && !clear_i && !power_fail_i;
    endsequence
    sequence scan_hyst_s;
        scan_tick && !clear_i && !power_fail_i && (on_thr >= off_thr);
    endsequence
    sequence scan_win_s;
        scan_tick && !clear_i && !power_fail_i && (on_thr < off_thr);
    endsequence
    sequence clear_held_s;
        clear_i ##1 clear_i;
    endsequence

    clear_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        clear_i |=> (cnt_q == CNT_RST)) else $error("count not cleared");
    clear_low_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        clear_i |=> !out_q) else $error("output high under clear");
    clear_held_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        clear_held_s |-> (!out_q && cnt_q == CNT_RST))
        else $error("held clear let output or count move");
    count_up_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (edge_seen && !dir_i && !clear_i && !power_fail_i && cnt_q < CNT_MAX)
        |=> cnt_q == $past(cnt_q) + 20'h00001) else $error("up step wrong");
    count_dn_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (edge_seen && dir_i && !clear_i && !power_fail_i && cnt_q != CNT_RST)
        |=> cnt_q == $past(cnt_q) - 20'h00001) else $error("down step wrong");
    no_edge_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (!edge_seen && !clear_i && !power_fail_i) |=> $stable(cnt_q))
        else $error("count moved without edge");
    fall_edge_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (pulse_q && !pulse_i && !clear_i && !power_fail_i) |=> $stable(cnt_q))
        else $error("falling edge counted");
    count_range_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        cnt_q <= CNT_MAX) else $error("count out of range");
    top_stop_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        live_edge_s ##0 (!dir_i && cnt_q == CNT_MAX) |=> (cnt_q == CNT_MAX))
        else $error("count wrapped at top");
    floor_stop_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        live_edge_s ##0 (dir_i && cnt_q == CNT_RST) |=> (cnt_q == CNT_RST))
        else $error("count wrapped at zero");
    scan_only_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (!scan_tick && !clear_i && !power_fail_i) |=> $stable(out_q))
        else $error("output moved between scans");
    window_out_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (scan_tick && !clear_i && !power_fail_i && on_thr < off_thr)
        |=> out_q == ($past(cnt_q) >= $past(on_thr) && $past(cnt_q) < $past(off_thr)))
        else $error("window output wrong");
    window_low_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        scan_win_s ##0 (cnt_q < on_thr || cnt_q >= off_thr) |=> !out_q)
        else $error("output high outside window");
    hyst_set_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        scan_hyst_s ##0 (cnt_q >= on_thr) |=> out_q)
        else $error("hysteresis set missed");
    hyst_clr_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        scan_hyst_s ##0 (cnt_q < off_thr) |=> !out_q)
        else $error("hysteresis clear missed");
    hyst_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (scan_tick && !clear_i && !power_fail_i && on_thr >= off_thr
         && cnt_q >= off_thr && cnt_q < on_thr) |=> $stable(out_q))
        else $error("hysteresis hold broken");
    fail_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (power_fail_i && !cfg_i.retain) |=> (cnt_q == CNT_RST && !out_q))
        else $error("power loss not zeroed");
    keep_count_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (power_fail_i && cfg_i.retain && !clear_i && !edge_seen) |=> $stable(cnt_q))
        else $error("retained count lost");
    fail_low_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        power_fail_i |=> !out_q)
        else $error("output kept over power loss");
    clamp_low_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (cfg_i.on_ext && on_src < 0) |-> (on_thr == CNT_RST))
        else $error("negative source not clamped");
    clamp_high_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (cfg_i.off_ext && off_src > EXT_TOP) |-> (off_thr == CNT_MAX))
        else $error("large source not clamped");
    live_on_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (cfg_i.on_ext && in_range(on_src)) |-> (on_thr == on_src[19:0]))
        else $error("on source value not used");
    live_off_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (cfg_i.off_ext && in_range(off_src)) |-> (off_thr == off_src[19:0]))
        else $error("off source value not used");
    local_on_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (!cfg_i.on_ext && cfg_i.on_thr > CNT_MAX) |-> (on_thr == CNT_MAX))
        else $error("local on limit not clamped");
    local_off_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (!cfg_i.off_ext && cfg_i.off_thr > CNT_MAX) |-> (off_thr == CNT_MAX))
        else $error("local off limit not clamped");
endmodule

// ### design/udc_pkg.sv
package udc_pkg;
    localparam int CNT_W = 20;
    localparam logic [19:0] CNT_MAX = 20'hF423F;
    localparam logic [19:0] CNT_RST = 20'h00000;
    localparam int SCAN_HZ = 1000;
    localparam int CLK_HZ = 20000000;
    localparam int SCAN_CYC = CLK_HZ / SCAN_HZ;
    localparam int EXT_W = 32;
    localparam int BLK_W = 4;

    typedef struct packed {
        logic [19:0] on_thr;
        logic [19:0] off_thr;
        logic on_ext;
        logic off_ext;
        logic [3:0] on_blk;
        logic [3:0] off_blk;
        logic retain;
    } udc_cfg_t;
endpackage

// ### design/udc_clamp.sv
`timescale 1ns/10ps
module udc_clamp
    import udc_pkg::*;
#(
    parameter int W = 32
) (
    input wire logic signed [W-1:0] val_i,
    output logic [19:0] thr_o
);
    // negative values round up to zero, large ones down to the top of range
    always_comb begin
        if (val_i < 0) begin
            thr_o = CNT_RST;
        end else if (val_i > $signed({{(W-20){1'b0}}, CNT_MAX})) begin
            thr_o = CNT_MAX;
        end else begin
            thr_o = val_i[19:0];
        end
    end
endmodule

// ### bench/udc_pulse_src.sv
`timescale 1ns/10ps
module udc_pulse_src (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic en_i,
    output logic pulse_o
);
    // each level lasts one cycle at least, so edges come at most every 2 cycles
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pulse_o <= 1'b0;
        end else if (en_i || pulse_o) begin
            pulse_o <= !pulse_o;
        end
    end
endmodule

// ### bench/up_down_threshold_counter_tb.sv
`timescale 1ns/10ps
module up_down_threshold_counter_tb;
    import udc_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic power_fail_i = 1'b0;
    logic clear_i = 1'b0;
    logic dir_i = 1'b0;
    logic en = 1'b0;
    logic pulse;
    udc_cfg_t cfg_i = '0;
    logic [16*EXT_W-1:0] blk = '0;
    logic [19:0] count_o;
    logic [19:0] exp_cnt;
    logic [19:0] on_v;
    logic [19:0] off_v;
    logic q_o;
    logic scan_o;
    logic exp_q;
    logic exp_scan;
    logic prev;
    localparam int SCAN_N = 8;
    int scan_n;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h1AFD7D53;
    always #25 sys_clk_i = ~sys_clk_i;
    udc_pulse_src src (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .en_i(en), .pulse_o(pulse));
    udc_counter #(.NBLK(16), .SCAN_CYCLES(SCAN_N)) uut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .power_fail_i(power_fail_i), .clear_i(clear_i), .pulse_i(pulse), .dir_i(dir_i),
        .cfg_i(cfg_i), .blk_vals_i(blk), .count_o(count_o), .q_o(q_o), .scan_o(scan_o));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [19:0] thr(input logic ext, input logic signed [31:0] v,
                                        input logic [19:0] loc);
        if (!ext) return (loc > CNT_MAX) ? CNT_MAX : loc;
        if (v < 0) return 20'h00000;
        return (v > $signed({12'h000, CNT_MAX})) ? CNT_MAX : v[19:0];
    endfunction
    assign on_v = thr(cfg_i.on_ext, blk[cfg_i.on_blk*EXT_W+:EXT_W], cfg_i.on_thr);
    assign off_v = thr(cfg_i.off_ext, blk[cfg_i.off_blk*EXT_W+:EXT_W], cfg_i.off_thr);
    assign exp_scan = (scan_n == SCAN_N - 1);
    // own scan counter paces the model; scan_o is checked against it
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            exp_cnt <= CNT_RST;
            exp_q <= 1'b0;
            prev <= 1'b0;
            scan_n <= 0;
        end else begin
            prev <= pulse;
            scan_n <= exp_scan ? 0 : scan_n + 1;
            if (clear_i || (power_fail_i && !cfg_i.retain)) exp_cnt <= CNT_RST;
            else if (pulse && !prev && !dir_i && exp_cnt != CNT_MAX)
                exp_cnt <= exp_cnt + 20'h00001;
            else if (pulse && !prev && dir_i && exp_cnt != CNT_RST)
                exp_cnt <= exp_cnt - 20'h00001;
            if (clear_i || power_fail_i) exp_q <= 1'b0;
            else if (exp_scan && on_v >= off_v)
                exp_q <= (exp_cnt >= on_v) ? 1'b1 : (exp_cnt < off_v) ? 1'b0 : exp_q;
            else if (exp_scan) exp_q <= (on_v <= exp_cnt) && (exp_cnt < off_v);
        end
    end
    // up and down biased phases keep the count near the small thresholds
    always @(posedge sys_clk_i) begin
        seed = xs(seed);
        en <= seed[0] | seed[1];
        dir_i <= cycles[8] ^ (seed[2] & seed[3]);
        clear_i <= (seed[15:8] == 8'h00);
        power_fail_i <= (seed[23:16] == 8'h00);
        blk[seed[31:28]*EXT_W+:EXT_W] <= (seed[27:26] == 2'h0) ? 32'hFFFFFFFB :
            (seed[27:26] == 2'h1) ? 32'h000F4240 : {26'h0000000, seed[13:8]};
        if (cycles[8:0] == 9'h000) begin
            cfg_i.on_thr <= seed[19] & seed[20] ? 20'hFFFFF : {14'h0000, seed[5:0]};
            cfg_i.off_thr <= seed[21] & seed[22] ? 20'hFFFFF : {14'h0000, seed[11:6]};
            cfg_i.on_ext <= seed[24];
            cfg_i.off_ext <= seed[25];
            cfg_i.on_blk <= seed[31:28];
            cfg_i.off_blk <= seed[27:24];
            cfg_i.retain <= cycles[10];
        end
    end
    task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(negedge sys_clk_i) begin
        cycles++;
        if (rstn_i) begin
            check("count", count_o, exp_cnt);
            check("scan", {19'h00000, scan_o}, {19'h00000, exp_scan});
            check("q", {19'h00000, q_o}, {19'h00000, exp_q});
        end
        if (cycles > 20000) begin
            errors++;
            complete_run();
        end
    end
    initial begin
        repeat (2) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        repeat (6000) @(posedge sys_clk_i);
        complete_run();
    end
endmodule
